// ### design/sbf_map.svh
`ifndef SBF_MAP_SVH
`define SBF_MAP_SVH

// Storage geometry.
`define SBF_DEPTH      10'd512
`define SBF_PTR_W      9
`define SBF_LVL_W      10

// Register offsets.
`define SBF_A_CTRL1    7'h07
`define SBF_A_CTRL2    7'h08
`define SBF_A_CTRL3    7'h09
`define SBF_A_MODE     7'h0a
`define SBF_A_ROUTE_A  7'h0d
`define SBF_A_ROUTE_B  7'h0e
`define SBF_A_HUB_CFG  7'h14
`define SBF_A_STAT1    7'h3a
`define SBF_A_STAT2    7'h3b
`define SBF_A_EMB_CFG  7'h44
`define SBF_A_EMB_EN   7'h45
`define SBF_A_EMB_INIT 7'h67
`define SBF_A_TAG      7'h78
`define SBF_A_OUT_XL   7'h79
`define SBF_A_OUT_ZH   7'h7e

// Field positions.
`define SBF_B_WATERMARK_MSB     0
`define SBF_B_CFGCHG   4
`define SBF_B_RT_EN    6
`define SBF_B_STOP     7
`define SBF_B_IRQ_TH   3
`define SBF_B_IRQ_OVR  4
`define SBF_B_IRQ_FULL 5
`define SBF_B_COMPR    3
`define SBF_B_STEP     1
`define SBF_B_REINIT   2
`define SBF_B_ST_WTM   7
`define SBF_B_ST_OVR   6
`define SBF_B_ST_FULL  5
`define SBF_B_ST_LAT   3

// Mode field codes.
`define SBF_M_BYPASS   3'h0
`define SBF_M_FIFO     3'h1
`define SBF_M_C2F      3'h3
`define SBF_M_B2C      3'h4
`define SBF_M_CONT     3'h6
`define SBF_M_B2F      3'h7

// Batch rate codes and forced raw periods.
`define SBF_BDR_OFF    4'h0
`define SBF_BDR_MAX    4'hb
`define SBF_RAW_P8     5'h07
`define SBF_RAW_P16    5'h0f
`define SBF_RAW_P32    5'h1f

// Tag byte and padding of the configuration-change meta entry.
`define SBF_TAG_CFG    8'h0e
`define SBF_PAD_CFG    40'h0

`endif

// ### design/sbf_pkg.sv
package sbf_pkg;

   typedef enum logic [1:0] {
      ST_BYP  = 2'b00,
      ST_FIFO = 2'b01,
      ST_CONT = 2'b10
   } sbf_st_type;

   // One stored word: tag byte then six data bytes, X low in bits 7:0.
   typedef struct packed {
      logic [7:0]  tag;
      logic [47:0] data;
   } sbf_word_type;

   typedef struct packed {
      sbf_st_type   st;
      logic [8:0]   wr_ptr;
      logic [8:0]   rd_ptr;
      logic [9:0]   cnt;
      logic         cur_valid;
      logic         ld_pend;
      sbf_word_type cur_word;
      logic [5:0]   mask;
      logic [7:0]   ctrl1;
      logic [7:0]   ctrl2;
      logic [7:0]   ctrl3;
      logic [2:0]   mode;
      logic         trig_seen;
      logic [7:0]   route_a;
      logic [7:0]   route_b;
      logic [7:0]   emb_en;
      logic [7:0]   emb_cfg;
      logic [7:0]   hub_cfg;
      logic         cfg_pend;
      logic         ovr;
      logic         ovr_lat;
      logic         wtm_flag;
      logic         full_flag;
      logic [4:0]   raw_cnt;
      logic         raw;
      logic         cact;
      logic         reinit;
      logic         irq_a;
      logic         irq_b;
      logic [7:0]   rdata;
   } sbf_state_type;

endpackage

// ### design/sbf_fifo.sv
`timescale 1ns/1ps
`include "sbf_map.svh"

module sbf_fifo (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   // Register port
   input  wire logic [6:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic [7:0]            reg_rdata,
   // Write sources and mode trigger
   input  wire logic             xlg_drdy,
   input  sbf_pkg::sbf_word_type xlg_word,
   input  wire logic             hub_drdy,
   input  wire logic [1:0]       hub_sel,
   input  sbf_pkg::sbf_word_type hub_word,
   input  wire logic             step_evt,
   input  sbf_pkg::sbf_word_type step_word,
   input  wire logic             trig_event,
   // Events and compression control
   output logic                  irq_line_a,
   output logic                  irq_line_b,
   output logic                  raw_write,
   output logic                  compress_active,
   output logic                  compress_reinit
);

   sbf_pkg::sbf_state_type s;
   sbf_pkg::sbf_state_type n;
   sbf_pkg::sbf_word_type  mem [0:`SBF_DEPTH-1];
   sbf_pkg::sbf_word_type  mem_q;
   sbf_pkg::sbf_word_type  wword;
   logic [8:0]             watermark_level;
   logic [9:0]             lim;
   logic [9:0]             lvl;
   logic                   full;
   logic                   wtm_hit;
   logic                   wreq;
   logic                   is_xlg;
   logic                   is_cfg;
   logic                   xlg_on;
   logic                   acc;
   logic                   drop;
   logic                   ld;
   logic                   rd_hit;
   logic                   word_read;
   logic                   ovr_evt;
   logic [2:0]             idx;
   logic [5:0]             mask_n;
   logic [4:0]             per;

   function automatic logic rate_on(input logic [3:0] code);
      rate_on = (code != `SBF_BDR_OFF) && (code <= `SBF_BDR_MAX);
   endfunction

   always_comb begin
      n         = s;
      n.raw     = 1'b0;
      n.reinit  = 1'b0;
      watermark_level       = {s.ctrl2[`SBF_B_WATERMARK_MSB], s.ctrl1};
      lim       = s.ctrl2[`SBF_B_STOP] ? {1'b0, watermark_level} : `SBF_DEPTH;
      lvl       = s.cnt + 10'(s.cur_valid);
      full      = lvl >= lim;
      wtm_hit   = lvl >= {1'b0, watermark_level};
      idx       = 3'(reg_addr - `SBF_A_OUT_XL);
      rd_hit    = reg_rd && s.cur_valid && (reg_addr >= `SBF_A_OUT_XL)
                  && (reg_addr <= `SBF_A_OUT_ZH);
      xlg_on    = rate_on(s.ctrl3[3:0]) || rate_on(s.ctrl3[7:4]);
      is_xlg    = 1'b0;
      is_cfg    = 1'b0;
      wreq      = 1'b1;
      wword     = xlg_word;
      // Fixed priority; a losing sensor pulse is dropped, the meta entry waits.
      if (xlg_drdy && xlg_on) begin
         is_xlg = 1'b1;
      end else if (hub_drdy && s.hub_cfg[hub_sel]) begin
         wword  = hub_word;
      end else if (step_evt && s.emb_cfg[`SBF_B_STEP]) begin
         wword  = step_word;
      end else if (s.cfg_pend) begin
         is_cfg = 1'b1;
         wword  = {`SBF_TAG_CFG, `SBF_PAD_CFG, s.ctrl3};
      end else begin
         wreq   = 1'b0;
      end
      ld        = s.ld_pend;
      acc       = 1'b0;
      drop      = 1'b0;
      ovr_evt   = 1'b0;
      if (wreq && s.st != sbf_pkg::ST_BYP) begin
         if (!full) begin
            acc = 1'b1;
         end else if (s.st == sbf_pkg::ST_CONT) begin
            ovr_evt = 1'b1;
            // Overwrite the oldest stored word; the presented word is never replaced.
            if (s.cnt > 10'(ld)) begin
               acc  = 1'b1;
               drop = 1'b1;
            end
         end
      end
      if (acc) begin
         n.wr_ptr = s.wr_ptr + 9'h001;
      end
      n.rd_ptr  = s.rd_ptr + 9'(ld) + 9'(drop);
      n.cnt     = s.cnt + 10'(acc) - 10'(ld) - 10'(drop);
      if (is_cfg && acc) begin
         n.cfg_pend = 1'b0;
      end
      // Read-out: outside a bypass flush, the word leaves only when all six data bytes were read.
      word_read = 1'b0;
      mask_n    = s.mask;
      if (rd_hit) begin
         mask_n = s.mask | (6'h01 << idx);
      end
      n.mask    = mask_n;
      if (&mask_n) begin
         n.cur_valid = 1'b0;
         n.mask      = 6'h00;
         word_read   = 1'b1;
      end
      if (ld) begin
         n.cur_word  = mem_q;
         n.cur_valid = 1'b1;
         n.ld_pend   = 1'b0;
      end else if (!s.cur_valid && s.cnt != 10'h000 && !drop) begin
         n.ld_pend   = 1'b1;
      end
      // Forced raw writes keep the compressed stream decodable after loss.
      case (s.ctrl2[2:1])
         2'b01:   per = `SBF_RAW_P8;
         2'b10:   per = `SBF_RAW_P16;
         2'b11:   per = `SBF_RAW_P32;
         default: per = 5'h00;
      endcase
      if (is_xlg && acc) begin
         if (!s.cact) begin
            n.raw = 1'b1;
         end else if (per != 5'h00 && s.raw_cnt >= per) begin
            n.raw     = 1'b1;
            n.raw_cnt = 5'h00;
         end else begin
            n.raw_cnt = s.raw_cnt + 5'h01;
         end
      end
      if (reg_rd && reg_addr == `SBF_A_STAT2) begin
         n.ovr_lat = 1'b0;
      end
      if (word_read) begin
         n.ovr = 1'b0;
      end
      if (ovr_evt) begin
         n.ovr     = 1'b1;
         n.ovr_lat = 1'b1;
      end
      if (reg_wr) begin
         case (reg_addr)
            `SBF_A_CTRL1:   n.ctrl1 = reg_wdata;
            `SBF_A_CTRL2:   n.ctrl2 = reg_wdata;
            `SBF_A_CTRL3:   n.ctrl3 = reg_wdata;
            `SBF_A_MODE: begin
               n.mode      = reg_wdata[2:0];
               n.trig_seen = 1'b0;
            end
            `SBF_A_ROUTE_A: n.route_a = reg_wdata;
            `SBF_A_ROUTE_B: n.route_b = reg_wdata;
            `SBF_A_HUB_CFG: n.hub_cfg = {4'h0, reg_wdata[3:0]};
            `SBF_A_EMB_CFG: n.emb_cfg = reg_wdata;
            `SBF_A_EMB_EN:  n.emb_en = reg_wdata;
            `SBF_A_EMB_INIT: begin
               if (reg_wdata[`SBF_B_REINIT]) begin
                  n.reinit  = 1'b1;
                  n.raw_cnt = 5'h00;
               end
            end
            default: ;
         endcase
      end
      if (reg_wr && reg_addr == `SBF_A_CTRL3 && reg_wdata != s.ctrl3
          && s.ctrl2[`SBF_B_CFGCHG]) begin
         n.cfg_pend = 1'b1;
      end
      if (trig_event) begin
         n.trig_seen = 1'b1;
      end
      case (n.mode)
         `SBF_M_FIFO: n.st = sbf_pkg::ST_FIFO;
         `SBF_M_CONT: n.st = sbf_pkg::ST_CONT;
         `SBF_M_C2F:  n.st = n.trig_seen ? sbf_pkg::ST_FIFO : sbf_pkg::ST_CONT;
         `SBF_M_B2C:  n.st = n.trig_seen ? sbf_pkg::ST_CONT : sbf_pkg::ST_BYP;
         `SBF_M_B2F:  n.st = n.trig_seen ? sbf_pkg::ST_FIFO : sbf_pkg::ST_BYP;
         default:     n.st = sbf_pkg::ST_BYP;
      endcase
      // Bypass keeps the buffer empty, so entering it flushes at once.
      if (n.st == sbf_pkg::ST_BYP) begin
         n.cnt       = 10'h000;
         n.wr_ptr    = 9'h000;
         n.rd_ptr    = 9'h000;
         n.cur_valid = 1'b0;
         n.ld_pend   = 1'b0;
         n.mask      = 6'h00;
      end
      n.cact      = n.emb_en[`SBF_B_COMPR] && n.ctrl2[`SBF_B_RT_EN];
      n.wtm_flag  = wtm_hit;
      n.full_flag = (11'(lvl) + 11'h001) >= 11'(lim);
      n.irq_a     = (n.full_flag && n.route_a[`SBF_B_IRQ_FULL])
                    || (n.wtm_flag && n.route_a[`SBF_B_IRQ_TH])
                    || (n.ovr && n.route_a[`SBF_B_IRQ_OVR]);
      n.irq_b     = (n.full_flag && n.route_b[`SBF_B_IRQ_FULL])
                    || (n.wtm_flag && n.route_b[`SBF_B_IRQ_TH])
                    || (n.ovr && n.route_b[`SBF_B_IRQ_OVR]);
      if (reg_rd) begin
         case (reg_addr)
            `SBF_A_CTRL1:    n.rdata = s.ctrl1;
            `SBF_A_CTRL2:    n.rdata = s.ctrl2;
            `SBF_A_CTRL3:    n.rdata = s.ctrl3;
            `SBF_A_MODE:     n.rdata = {5'h00, s.mode};
            `SBF_A_ROUTE_A:  n.rdata = s.route_a;
            `SBF_A_ROUTE_B:  n.rdata = s.route_b;
            `SBF_A_HUB_CFG:  n.rdata = s.hub_cfg;
            `SBF_A_EMB_CFG:  n.rdata = s.emb_cfg;
            `SBF_A_EMB_EN:   n.rdata = s.emb_en;
            `SBF_A_STAT1:    n.rdata = lvl[7:0];
            `SBF_A_STAT2:    n.rdata = {s.wtm_flag, s.ovr, s.full_flag, 1'b0,
                                        s.ovr_lat, 1'b0, lvl[9:8]};
            `SBF_A_TAG:      n.rdata = s.cur_valid ? s.cur_word.tag : 8'h00;
            default: begin
               n.rdata = 8'h00;
               if (rd_hit) begin
                  n.rdata = s.cur_word.data[8*idx +: 8];
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // Storage array is kept outside the state record; it needs no reset.
   always_ff @(posedge sys_clk) begin
      if (acc) begin
         mem[s.wr_ptr] <= wword;
      end
      mem_q <= mem[s.rd_ptr];
   end

   assign reg_rdata       = s.rdata;
   assign irq_line_a      = s.irq_a;
   assign irq_line_b      = s.irq_b;
   assign raw_write       = s.raw;
   assign compress_active = s.cact;
   assign compress_reinit = s.reinit;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   a_level_bound: assert property (lvl <= `SBF_DEPTH)
      else $error("stored level exceeds depth");
   a_wtm_flag: assert property ($past(resetn) |-> s.wtm_flag == $past(wtm_hit))
      else $error("threshold flag does not follow level");
   a_bypass_empty: assert property (s.st == sbf_pkg::ST_BYP |-> lvl == 10'h000)
      else $error("bypass state holds words");
   a_fifo_stop: assert property ((s.st == sbf_pkg::ST_FIFO && full && wreq
      && n.st == sbf_pkg::ST_FIFO) |=> s.wr_ptr == $past(s.wr_ptr))
      else $error("write taken while full in fifo state");
   a_ovr_set: assert property (drop |=> s.ovr && s.ovr_lat)
      else $error("overwrite did not raise overrun");
   a_irq_route: assert property (s.irq_a == ((s.full_flag && s.route_a[`SBF_B_IRQ_FULL])
      || (s.wtm_flag && s.route_a[`SBF_B_IRQ_TH]) || (s.ovr && s.route_a[`SBF_B_IRQ_OVR])))
      else $error("line a routing wrong");
   a_pop_read: assert property ($fell(s.cur_valid) |-> $past(rd_hit)
      || s.st == sbf_pkg::ST_BYP)
      else $error("word left without full read");
   a_tag_data: assert property ($rose(s.cur_valid) |-> s.cur_word == $past(mem_q))
      else $error("presented word not taken from storage");
   a_reinit_pulse: assert property ((reg_wr && reg_addr == `SBF_A_EMB_INIT
      && reg_wdata[`SBF_B_REINIT]) |=> s.reinit && s.raw_cnt == 5'h00)
      else $error("reinit request lost");
   a_cfg_pend: assert property ((reg_wr && reg_addr == `SBF_A_CTRL3 && reg_wdata != s.ctrl3
      && s.ctrl2[`SBF_B_CFGCHG]) |=> s.cfg_pend)
      else $error("config change not queued");
   a_raw_off: assert property ((is_xlg && acc && !s.cact) |=> s.raw)
      else $error("uncompressed write not marked");

   c_overwrite: cover property (drop);
   c_word_read: cover property ($fell(s.cur_valid) && s.st != sbf_pkg::ST_BYP);
   c_cfg_entry: cover property (s.cfg_pend ##[1:20] !s.cfg_pend);
   c_full: cover property (s.full_flag && s.st == sbf_pkg::ST_FIFO);

endmodule // sbf_fifo

// ### dv/sbf_host_model.sv
`timescale 1ns/1ps

// Host side of the register port: one strobe per access, released lines go to
// the inverse of their last value so a stale address or datum is never reused.
module sbf_host_model (
   // Clock
   input  wire logic       sys_clk,
   // Register port toward the device
   output logic [6:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 7'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~v;
      // Outputs launched by the write edge are settled only after it.
      #1;
   endtask

   // Read data is registered, so it is taken just after the edge that took the read.
   task automatic rd(input logic [6:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      v = reg_rdata;
   endtask
endmodule // sbf_host_model

// ### dv/sbf_fifo_tb_top.sv
`timescale 1ns/1ps
`include "sbf_map.svh"

module sbf_fifo_tb_top;
   logic                  sys_clk;
   logic                  resetn;
   logic [6:0]            reg_addr;
   logic [7:0]            reg_wdata;
   logic                  reg_wr;
   logic                  reg_rd;
   logic [7:0]            reg_rdata;
   logic                  xlg_drdy;
   logic                  hub_drdy;
   logic                  step_evt;
   logic                  trig_event;
   logic [1:0]            hub_sel;
   sbf_pkg::sbf_word_type xlg_word;
   sbf_pkg::sbf_word_type hub_word;
   sbf_pkg::sbf_word_type step_word;
   logic                  irq_line_a;
   logic                  irq_line_b;
   logic                  raw_write;
   logic                  compress_active;
   logic                  compress_reinit;
   int                    miscompares;
   int                    check_count;
   int                    raw_seen;
   int                    reinit_seen;
   int                    r0;
   logic [7:0]            d;
   sbf_pkg::sbf_word_type w [0:4];
   int                    raw_exp [0:3];

   sbf_host_model u_sbf_host_model (.sys_clk(sys_clk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   sbf_fifo u_sbf_fifo (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .xlg_drdy(xlg_drdy), .xlg_word(xlg_word), .hub_drdy(hub_drdy), .hub_sel(hub_sel),
      .hub_word(hub_word), .step_evt(step_evt), .step_word(step_word),
      .trig_event(trig_event), .irq_line_a(irq_line_a), .irq_line_b(irq_line_b),
      .raw_write(raw_write), .compress_active(compress_active),
      .compress_reinit(compress_reinit));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      if (raw_write === 1'b1) raw_seen <= raw_seen + 1;
      if (compress_reinit === 1'b1) reinit_seen <= reinit_seen + 1;
   end

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      u_sbf_host_model.wr(a, v);
   endtask

   task automatic rdc(input string n, input logic [6:0] a, input logic [7:0] e);
      logic [7:0] g;
      u_sbf_host_model.rd(a, g);
      chk(n, e, g);
   endtask

   function automatic sbf_pkg::sbf_word_type mkw(input logic [7:0] t, input logic [7:0] n);
      mkw = {t, {6{n}} ^ 48'h5a4b3c2d1e0f};
   endfunction

   // Source 0 is accel/gyro, 1 the hub, 2 the step detector.
   task automatic push(input int src, input sbf_pkg::sbf_word_type v, input logic [1:0] s);
      @(posedge sys_clk);
      xlg_word <= v;
      hub_word <= v;
      step_word <= v;
      hub_sel <= s;
      xlg_drdy <= (src == 0);
      hub_drdy <= (src == 1);
      step_evt <= (src == 2);
      @(posedge sys_clk);
      xlg_drdy <= 1'b0;
      hub_drdy <= 1'b0;
      step_evt <= 1'b0;
      xlg_word <= sbf_pkg::sbf_word_type'(~v);
      hub_word <= sbf_pkg::sbf_word_type'(~v);
      step_word <= sbf_pkg::sbf_word_type'(~v);
   endtask

   // The tag is read again before the last byte: it must not have moved on.
   task automatic rword(input sbf_pkg::sbf_word_type e);
      repeat (4) @(posedge sys_clk);
      rdc("tag", `SBF_A_TAG, e.tag);
      for (int i = 0; i < 6; i++) begin
         if (i == 5) rdc("tag held", `SBF_A_TAG, e.tag);
         rdc("data byte", 7'(`SBF_A_OUT_XL + i), e.data[8*i +: 8]);
      end
   endtask

   task automatic mode(input logic [2:0] m);
      wr(`SBF_A_MODE, 8'h00);
      wr(`SBF_A_MODE, {5'h00, m});
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      $display("watchdog expired");
      tally_and_finish();
   end

   initial begin
      resetn = 1'b0;
      {xlg_drdy, hub_drdy, step_evt, trig_event, hub_sel} = 6'h00;
      xlg_word = '0;
      hub_word = '0;
      step_word = '0;
      {miscompares, check_count, raw_seen, reinit_seen} = {4{32'sd0}};
      raw_exp = '{0, 4, 2, 1};
      repeat (6) @(posedge sys_clk);
      resetn <= 1'b1;
      rdc("ctrl1 reset", `SBF_A_CTRL1, 8'h00);
      rdc("ctrl2 reset", `SBF_A_CTRL2, 8'h00);
      rdc("ctrl3 reset", `SBF_A_CTRL3, 8'h00);
      rdc("level reset", `SBF_A_STAT1, 8'h00);
      wr(7'h50, 8'h5a);
      rdc("unmapped", 7'h50, 8'h00);
      wr(`SBF_A_STAT1, 8'h33);
      rdc("status ro", `SBF_A_STAT1, 8'h00);
      rdc("empty data", `SBF_A_OUT_XL, 8'h00);
      wr(`SBF_A_CTRL1, 8'ha5);
      rdc("ctrl1 rw", `SBF_A_CTRL1, 8'ha5);
      wr(`SBF_A_CTRL1, 8'h00);
      // Rates kept at or below the sensor output rates throughout.
      wr(`SBF_A_CTRL3, 8'h01);
      push(0, mkw(8'h11, 8'h01), 2'd0);
      rdc("bypass level", `SBF_A_STAT1, 8'h00);
      mode(`SBF_M_B2F);
      push(0, mkw(8'h11, 8'h02), 2'd0);
      rdc("wait trigger", `SBF_A_STAT1, 8'h00);
      @(posedge sys_clk) trig_event <= 1'b1;
      @(posedge sys_clk) trig_event <= 1'b0;
      push(0, mkw(8'h11, 8'h03), 2'd0);
      rdc("after trigger", `SBF_A_STAT1, 8'h01);
      mode(`SBF_M_FIFO);
      wr(`SBF_A_CTRL2, 8'h10);
      wr(`SBF_A_CTRL3, 8'h02);
      wr(`SBF_A_CTRL2, 8'h00);
      w[0] = {`SBF_TAG_CFG, `SBF_PAD_CFG, 8'h02};
      w[1] = mkw(8'h11, 8'h01);
      w[2] = mkw(8'h21, 8'h02);
      w[3] = mkw(8'h23, 8'h04);
      w[4] = mkw(8'h31, 8'h05);
      wr(`SBF_A_HUB_CFG, 8'h05);
      push(2, w[4], 2'd0);
      wr(`SBF_A_EMB_CFG, 8'h02);
      push(0, w[1], 2'd0);
      push(1, w[2], 2'd0);
      push(1, mkw(8'h22, 8'h03), 2'd1);
      push(1, w[3], 2'd2);
      push(2, w[4], 2'd0);
      rdc("mixed level", `SBF_A_STAT1, 8'h05);
      for (int i = 0; i < 5; i++) rword(w[i]);
      rdc("drained", `SBF_A_STAT1, 8'h00);
      mode(`SBF_M_FIFO);
      for (int c = 0; c < 12; c++) begin
         wr(`SBF_A_CTRL3, 8'(c));
         push(0, mkw(8'h11, 8'(c)), 2'd0);
      end
      wr(`SBF_A_CTRL3, 8'hb0);
      push(0, mkw(8'h12, 8'h0c), 2'd0);
      rdc("rate codes", `SBF_A_STAT1, 8'h0c);
      mode(`SBF_M_FIFO);
      for (int i = 0; i < 513; i++) push(0, mkw(8'h11, 8'(i)), 2'd0);
      rdc("cap low", `SBF_A_STAT1, 8'h00);
      rdc("cap high", `SBF_A_STAT2, 8'ha2);
      mode(`SBF_M_FIFO);
      wr(`SBF_A_CTRL2, 8'h01);
      push(0, mkw(8'h11, 8'h07), 2'd0);
      rdc("wtm 256", `SBF_A_STAT2, 8'h00);
      wr(`SBF_A_CTRL2, 8'h00);
      wr(`SBF_A_CTRL1, 8'h01);
      rdc("wtm equal", `SBF_A_STAT2, 8'h80);
      wr(`SBF_A_ROUTE_A, 8'h08);
      chk("irq a wtm", 8'h01, {7'h00, irq_line_a});
      chk("irq b off", 8'h00, {7'h00, irq_line_b});
      wr(`SBF_A_ROUTE_A, 8'h00);
      wr(`SBF_A_CTRL1, 8'h03);
      wr(`SBF_A_CTRL2, 8'h80);
      for (int i = 0; i < 4; i++) push(0, mkw(8'h11, 8'(i)), 2'd0);
      rdc("stop level", `SBF_A_STAT1, 8'h03);
      rdc("stop flags", `SBF_A_STAT2, 8'ha0);
      wr(`SBF_A_MODE, {5'h00, `SBF_M_CONT});
      push(0, mkw(8'h11, 8'h09), 2'd0);
      wr(`SBF_A_ROUTE_A, 8'h10);
      wr(`SBF_A_ROUTE_B, 8'h20);
      chk("irq a ovr", 8'h01, {7'h00, irq_line_a});
      chk("irq b full", 8'h01, {7'h00, irq_line_b});
      rdc("ovr flags", `SBF_A_STAT2, 8'he8);
      rdc("latch clear", `SBF_A_STAT2, 8'he0);
      for (int i = 0; i < 6; i++) u_sbf_host_model.rd(7'(`SBF_A_OUT_XL + i), d);
      repeat (4) @(posedge sys_clk);
      u_sbf_host_model.rd(`SBF_A_STAT2, d);
      chk("ovr clear", 8'h00, d & 8'h40);
      wr(`SBF_A_ROUTE_A, 8'h00);
      wr(`SBF_A_ROUTE_B, 8'h00);
      mode(`SBF_M_CONT);
      wr(`SBF_A_EMB_EN, 8'h08);
      for (int k = 0; k < 4; k++) begin
         wr(`SBF_A_CTRL2, 8'h40 | 8'(k << 1));
         chk("compress on", 8'h01, {7'h00, compress_active});
         r0 = reinit_seen;
         wr(`SBF_A_EMB_INIT, 8'h04);
         @(posedge sys_clk);
         #1;
         chk("reinit", 8'h01, 8'(reinit_seen - r0));
         r0 = raw_seen;
         for (int i = 0; i < 32; i++) push(0, mkw(8'h11, 8'(i)), 2'd0);
         repeat (3) @(posedge sys_clk);
         chk("raw count", 8'(raw_exp[k]), 8'(raw_seen - r0));
      end
      wr(`SBF_A_CTRL2, 8'h00);
      chk("compress off", 8'h00, {7'h00, compress_active});
      r0 = raw_seen;
      for (int i = 0; i < 4; i++) push(0, mkw(8'h11, 8'(i)), 2'd0);
      repeat (3) @(posedge sys_clk);
      chk("raw all", 8'h04, 8'(raw_seen - r0));
      wr(`SBF_A_CTRL2, 8'h40);
      wr(`SBF_A_EMB_EN, 8'h00);
      chk("embedded off", 8'h00, {7'h00, compress_active});
      tally_and_finish();
   end
endmodule // sbf_fifo_tb_top
